// ==== design/asicm_pkg.sv ====
package asicm_pkg;
    typedef enum logic [1:0]
    {
        ASICM_FMT_I2S = 2'h0,
        ASICM_FMT_LJ  = 2'h1,
        ASICM_FMT_RJ  = 2'h2
    } asicm_fmt_type;
    typedef enum logic [1:0]
    {
        ASICM_WL_16 = 2'h0,
        ASICM_WL_20 = 2'h1,
        ASICM_WL_24 = 2'h2
    } asicm_wlen_type;
    localparam int          SAMPLE_W        = 24;
    localparam logic [6:0]  RATIO_32        = 7'h20;
    localparam logic [6:0]  RATIO_48        = 7'h30;
    localparam logic [6:0]  RATIO_64        = 7'h40;
    localparam int          STABLE_FRAMES   = 4;
    localparam int          PLL_MULT        = 512;
    localparam int          RAMP_STEP_CYC   = 16;
    localparam logic [7:0]  VOL_FULL        = 8'hFF;
    localparam logic [7:0]  RESET_VOL_VALUE = 8'h00;
    localparam int          SRC_DIV_HALF    = 6;
    localparam logic [6:0]  WD_LIMIT        = 7'h7F;
endpackage

// ==== design/asicm_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface asicm_link_if;
    logic mclk;
    logic bclk;
    logic lrclk;
    logic serial_audio_in;
    modport source
    (
        output mclk,
        output bclk,
        output lrclk,
        output serial_audio_in
    );
    modport sink
    (
        input mclk,
        input bclk,
        input lrclk,
        input serial_audio_in
    );
endinterface
`default_nettype wire

// ==== design/asicm_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module asicm_sync2
(
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== design/asicm_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
module asicm_receiver
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    asicm_link_if.sink                 link,
    input  wire asicm_pkg::asicm_fmt_type  fmt,
    input  wire asicm_pkg::asicm_wlen_type wlen,
    input  wire logic                  soft_unmute,
    output logic [23:0]                left_sample,
    output logic                       left_valid,
    output logic [23:0]                right_sample,
    output logic                       right_valid,
    output logic                       muted,
    output logic                       pll_limp,
    output logic                       rate_locked,
    output logic [1:0]                 rate_code,
    output logic [7:0]                 volume,
    output logic                       pclk_from_mclk
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        ASICM_ST_LIMP   = 3'b001,
        ASICM_ST_RUN    = 3'b010,
        ASICM_ST_UNMUTE = 3'b100
    } asicm_state_type;

    logic bclk_s;
    logic lrclk_s;
    logic serial_audio_in_s;
    logic mclk_s;
    // single clock may serve as mclk and bclk; each sampled independently
    asicm_sync2 u_sync_bclk  (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(link.bclk),
                              .dout(bclk_s));
    asicm_sync2 u_sync_lrclk (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(link.lrclk),
                              .dout(lrclk_s));
    asicm_sync2 u_sync_serial_audio_in  (.clk_sys(clk_sys), .sys_rst(sys_rst),
                              .din(link.serial_audio_in), .dout(serial_audio_in_s));
    asicm_sync2 u_sync_mclk  (.clk_sys(clk_sys), .sys_rst(sys_rst), .din(link.mclk),
                              .dout(mclk_s));

    ////////////////////////////////////////////////////////////////////////////
    logic            bclk_d_reg;
    logic            mclk_d_reg;
    logic            lr_last_reg;
    logic            first_reg;
    logic [6:0]      bitcnt_reg;
    logic [6:0]      wd_reg;
    logic [6:0]      mwd_reg;
    logic [23:0]     shift_reg;
    logic [6:0]      ratio_reg;
    logic [2:0]      stable_reg;
    logic            clk_err;
    logic            ratio_ok;
    logic            bclk_rise;
    logic            lr_edge;
    logic [4:0]      wbits;
    logic            lr_is_left;
    logic            take_bit;
    logic [6:0]      pos;
    logic [6:0]      slot_pos;
    logic            frame_start;
    logic            take_first;
    asicm_state_type state_reg;
    logic [4:0]      ramp_reg;

    assign bclk_rise = bclk_s & ~bclk_d_reg;
    assign lr_edge   = bclk_rise & (lrclk_s != lr_last_reg);
    // left slot opens a frame: I2S on low level, LJ/RJ on high level
    assign frame_start = lr_edge & (lrclk_s == (fmt != asicm_pkg::ASICM_FMT_I2S));
    assign ratio_ok  = (bitcnt_reg == asicm_pkg::RATIO_32) ||
                       (bitcnt_reg == asicm_pkg::RATIO_48) ||
                       (bitcnt_reg == asicm_pkg::RATIO_64);

    always_comb
    begin
        unique case (wlen)
            asicm_pkg::ASICM_WL_16: wbits = 5'd16;
            asicm_pkg::ASICM_WL_20: wbits = 5'd20;
            default:                wbits = 5'd24;
        endcase
    end

    // bit position within current channel slot, counted from slot edge
    assign pos      = bitcnt_reg - {1'b0, ratio_reg[6:1]};
    assign slot_pos = (bitcnt_reg >= {1'b0, ratio_reg[6:1]}) ? pos : bitcnt_reg;
    // position 0 is sampled on the slot edge itself
    assign take_first = (fmt == asicm_pkg::ASICM_FMT_LJ) || ((fmt == asicm_pkg::ASICM_FMT_RJ) &&
                        ({1'b0, ratio_reg[6:1]} == {2'b0, wbits}));

    always_comb
    begin
        take_bit = 1'b0;
        unique case (fmt)
            asicm_pkg::ASICM_FMT_I2S:
                // one bit delay, trailing bits dropped
                take_bit = (slot_pos >= 7'h01) && (slot_pos <= {2'b0, wbits});
            asicm_pkg::ASICM_FMT_LJ:
                take_bit = slot_pos < {2'b0, wbits};
            default:
                // leading positions skipped so LSB lands last
                take_bit = slot_pos >= ({1'b0, ratio_reg[6:1]} - {2'b0, wbits});
        endcase
    end

    // I2S low=left; LJ/RJ high=left
    assign lr_is_left = (fmt == asicm_pkg::ASICM_FMT_I2S) ? ~lr_last_reg : lr_last_reg;

    ////////////////////////////////////////////////////////////////////////////
    // bit-clock edge tracking and frame counting
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bclk_d_reg  <= 1'b0;
            lr_last_reg <= 1'b0;
            bitcnt_reg  <= 7'h00;
            first_reg   <= 1'b1;
        end
        else
        begin
            bclk_d_reg <= bclk_s;
            if (bclk_rise)
            begin
                lr_last_reg <= lrclk_s;
                if (frame_start)
                begin
                    bitcnt_reg <= 7'h01;
                    first_reg  <= 1'b0;
                end
                else if (bitcnt_reg != asicm_pkg::WD_LIMIT)
                    bitcnt_reg <= bitcnt_reg + 7'h01;
            end
        end
    end

    // ratio capture: one frame clock period per sample
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ratio_reg <= asicm_pkg::RATIO_64;
        else if (frame_start & ratio_ok & ~first_reg)
            ratio_reg <= bitcnt_reg;
    end

    // watchdogs on bit clock and master clock
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wd_reg     <= 7'h00;
            mwd_reg    <= 7'h00;
            mclk_d_reg <= 1'b0;
        end
        else
        begin
            mclk_d_reg <= mclk_s;
            wd_reg     <= bclk_rise ? 7'h00 :
                          (wd_reg == asicm_pkg::WD_LIMIT ? wd_reg : wd_reg + 7'h01);
            mwd_reg    <= (mclk_s & ~mclk_d_reg) ? 7'h00 :
                          (mwd_reg == asicm_pkg::WD_LIMIT ? mwd_reg : mwd_reg + 7'h01);
        end
    end

    assign clk_err = (wd_reg == asicm_pkg::WD_LIMIT) ||
                     (frame_start & ~first_reg & ~ratio_ok) ||
                     (bitcnt_reg == asicm_pkg::WD_LIMIT);

    ////////////////////////////////////////////////////////////////////////////
    // serial word capture
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            shift_reg    <= 24'h000000;
            left_sample  <= 24'h000000;
            right_sample <= 24'h000000;
            left_valid   <= 1'b0;
            right_valid  <= 1'b0;
        end
        else
        begin
            left_valid  <= 1'b0;
            right_valid <= 1'b0;
            if (bclk_rise & lr_edge)
            begin
                // slot closed: left-align signed word, zero fill
                if (lr_is_left)
                begin
                    left_sample <= shift_reg << (5'd24 - wbits);
                    left_valid  <= ~muted & ~clk_err;
                end
                else
                begin
                    right_sample <= shift_reg << (5'd24 - wbits);
                    right_valid  <= ~muted & ~clk_err;
                end
                shift_reg <= {23'h000000, take_first & serial_audio_in_s};
            end
            else if (bclk_rise & take_bit)
                shift_reg <= {shift_reg[22:0], serial_audio_in_s};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock supervision: mute, limp, relock, unmute
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg   <= ASICM_ST_LIMP;
            stable_reg  <= 3'h0;
            ramp_reg    <= 5'h00;
            muted       <= 1'b1;
            pll_limp    <= 1'b1;
            rate_locked <= 1'b0;
            volume      <= asicm_pkg::RESET_VOL_VALUE;
        end
        else
        begin
            unique case (state_reg)
                ASICM_ST_RUN:
                    if (clk_err)
                    begin
                        muted       <= 1'b1;
                        volume      <= asicm_pkg::RESET_VOL_VALUE;
                        pll_limp    <= 1'b1;
                        rate_locked <= 1'b0;
                        stable_reg  <= 3'h0;
                        state_reg   <= ASICM_ST_LIMP;
                    end
                ASICM_ST_LIMP:
                    if (clk_err)
                        stable_reg <= 3'h0;
                    else if (frame_start & ratio_ok & ~first_reg)
                    begin
                        if (stable_reg == 3'(asicm_pkg::STABLE_FRAMES))
                        begin
                            pll_limp    <= 1'b0;
                            rate_locked <= 1'b1;
                            muted       <= 1'b0;
                            if (soft_unmute)
                                state_reg <= ASICM_ST_UNMUTE;
                            else
                            begin
                                volume    <= asicm_pkg::VOL_FULL;
                                state_reg <= ASICM_ST_RUN;
                            end
                        end
                        else
                            stable_reg <= stable_reg + 3'h1;
                    end
                ASICM_ST_UNMUTE:
                    if (clk_err)
                    begin
                        muted       <= 1'b1;
                        volume      <= asicm_pkg::RESET_VOL_VALUE;
                        pll_limp    <= 1'b1;
                        rate_locked <= 1'b0;
                        stable_reg  <= 3'h0;
                        state_reg   <= ASICM_ST_LIMP;
                    end
                    else
                    begin
                        ramp_reg <= ramp_reg + 5'h01;
                        if (ramp_reg == 5'(asicm_pkg::RAMP_STEP_CYC - 1))
                        begin
                            ramp_reg <= 5'h00;
                            volume <= volume + 8'h01;
                            if (volume == asicm_pkg::VOL_FULL - 8'h01)
                                state_reg <= ASICM_ST_RUN;
                        end
                    end
                default:
                    state_reg <= ASICM_ST_LIMP;
            endcase
        end
    end

    // processing-clock source select and rate code
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pclk_from_mclk <= 1'b0;
            rate_code      <= 2'h0;
        end
        else
        begin
            // master clock only when present and link locked
            pclk_from_mclk <= (mwd_reg != asicm_pkg::WD_LIMIT) & rate_locked;
            rate_code      <= (ratio_reg == asicm_pkg::RATIO_32) ? 2'h0 :
                              (ratio_reg == asicm_pkg::RATIO_48) ? 2'h1 : 2'h2;
        end
    end
endmodule
`default_nettype wire

// ==== design/asicm_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module asicm_source
(
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    asicm_link_if.source                   link,
    input  wire asicm_pkg::asicm_fmt_type  fmt,
    input  wire asicm_pkg::asicm_wlen_type wlen,
    input  wire logic [6:0]                ratio,
    input  wire logic [23:0]               left_in,
    input  wire logic [23:0]               right_in,
    output logic                           sample_take
);
    logic [2:0]  div_reg;
    logic        bclk_reg;
    logic [6:0]  bit_reg;
    logic [23:0] lw_reg;
    logic [23:0] rw_reg;
    logic [5:0]  half;
    logic [6:0]  pos;
    logic [4:0]  wbits;
    logic [6:0]  idx;
    logic        chan_left;
    logic        dbit;

    assign half = ratio[6:1];
    assign wbits = (wlen == asicm_pkg::ASICM_WL_16) ? 5'd16 :
                   (wlen == asicm_pkg::ASICM_WL_20) ? 5'd20 : 5'd24;
    assign chan_left = bit_reg < {1'b0, half};
    assign pos = chan_left ? bit_reg : bit_reg - {1'b0, half};

    always_comb
    begin
        idx  = 7'h00;
        dbit = 1'b0;
        unique case (fmt)
            asicm_pkg::ASICM_FMT_I2S:
            begin
                idx  = pos - 7'h01;
                dbit = (pos != 7'h00) && (idx < {2'b0, wbits});
            end
            asicm_pkg::ASICM_FMT_LJ:
            begin
                idx  = pos;
                dbit = idx < {2'b0, wbits};
            end
            default:
            begin
                idx  = pos - ({1'b0, half} - {2'b0, wbits});
                dbit = pos >= ({1'b0, half} - {2'b0, wbits});
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit clock divided from system clock; data changes on falling edge
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            div_reg     <= 3'h0;
            bclk_reg    <= 1'b0;
            bit_reg     <= 7'h00;
            lw_reg      <= 24'h000000;
            rw_reg      <= 24'h000000;
            sample_take <= 1'b0;
            link.bclk            <= 1'b0;
            link.mclk            <= 1'b0;
            link.lrclk           <= 1'b0;
            link.serial_audio_in <= 1'b0;
        end
        else
        begin
            sample_take <= 1'b0;
            link.mclk   <= ~link.mclk;
            div_reg     <= (div_reg == 3'(asicm_pkg::SRC_DIV_HALF - 1)) ? 3'h0 : div_reg + 3'h1;
            if (div_reg == 3'(asicm_pkg::SRC_DIV_HALF - 1))
            begin
                bclk_reg  <= ~bclk_reg;
                link.bclk <= ~bclk_reg;
                if (bclk_reg)
                begin
                    // falling edge: present the bit at bit_reg, then advance
                    link.lrclk <= (fmt == asicm_pkg::ASICM_FMT_I2S) ? ~chan_left
                                                                    : chan_left;
                    link.serial_audio_in <= dbit &
                        (chan_left ? lw_reg[5'(5'd23 - 5'(idx))]
                                   : rw_reg[5'(5'd23 - 5'(idx))]);
                    bit_reg <= (bit_reg == ratio - 7'h01) ? 7'h00 : bit_reg + 7'h01;
                    if (bit_reg == ratio - 7'h01)
                    begin
                        lw_reg      <= left_in;
                        rw_reg      <= right_in;
                        sample_take <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/asicm_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module asicm_checker
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       mclk,
    input wire logic       bclk,
    input wire logic       lrclk,
    input wire logic       soft_unmute,
    input wire logic       left_valid,
    input wire logic       right_valid,
    input wire logic       muted,
    input wire logic       pll_limp,
    input wire logic       rate_locked,
    input wire logic [7:0] volume,
    input wire logic       pclk_from_mclk
);
    logic       bclk_d_reg;
    logic       mclk_d_reg;
    logic       lr_d_reg;
    logic [7:0] bclk_idle_reg;
    logic [7:0] mclk_idle_reg;
    logic [7:0] lr_age_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // link edge detection and idle counters
    always_ff @(posedge clk_sys)
    begin
        bclk_d_reg <= bclk;
        mclk_d_reg <= mclk;
        lr_d_reg   <= lrclk;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || bclk != bclk_d_reg)
            bclk_idle_reg <= 8'h00;
        else if (bclk_idle_reg != 8'hFF)
            bclk_idle_reg <= bclk_idle_reg + 8'h01;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || mclk != mclk_d_reg)
            mclk_idle_reg <= 8'h00;
        else if (mclk_idle_reg != 8'hFF)
            mclk_idle_reg <= mclk_idle_reg + 8'h01;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || lrclk != lr_d_reg)
            lr_age_reg <= 8'h00;
        else if (lr_age_reg != 8'hFF)
            lr_age_reg <= lr_age_reg + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////////
    left_quiet_a: assert property (left_valid |-> !muted)
        else $error("left strobe while muted");
    right_quiet_a: assert property (right_valid |-> !muted)
        else $error("right strobe while muted");
    mute_limp_a: assert property ($rose(muted) |-> ##[0:8] pll_limp)
        else $error("mute without limp mode");
    mute_step_a: assert property ($rose(muted) |-> ##[0:2] volume == 8'h00)
        else $error("mute not single step");
    watchdog_a: assert property (bclk_idle_reg == 8'h8C |-> ##[0:8] muted)
        else $error("stopped bit clock not muted");
    hard_unmute_a: assert property (!soft_unmute && $fell(muted) |-> ##[0:2] volume == 8'hFF)
        else $error("hard unmute not full volume");
    normal_op_a: assert property (!muted |-> rate_locked && !pll_limp)
        else $error("audio on without lock");
    soft_ramp_a: assert property (soft_unmute && !muted && !$past(muted) && volume != $past(volume)
        |-> volume == $past(volume) + 8'h01)
        else $error("soft unmute step not one");
    mclk_gone_a: assert property (mclk_idle_reg == 8'h8C |-> ##[0:8] !pclk_from_mclk)
        else $error("absent master clock still used");
    strobe_time_a: assert property (left_valid || right_valid |-> lr_age_reg <= 8'h14)
        else $error("strobe far from slot end");
    pulse_a: assert property (left_valid |=> !left_valid)
        else $error("left strobe longer than one cycle");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                      clk_sys     = 1'b0;
    logic                      sys_rst     = 1'b1;
    logic                      src_rst     = 1'b1;
    asicm_pkg::asicm_fmt_type  fmt         = asicm_pkg::ASICM_FMT_I2S;
    asicm_pkg::asicm_wlen_type wlen        = asicm_pkg::ASICM_WL_24;
    logic [6:0]                ratio       = asicm_pkg::RATIO_64;
    logic                      soft_unmute = 1'b0;
    logic [23:0]               left_in     = 24'h8A5C3E;
    logic [23:0]               right_in    = 24'h3C96A5;
    logic [23:0]               left_sample;
    logic [23:0]               right_sample;
    logic                      left_valid;
    logic                      right_valid;
    logic                      muted;
    logic                      pll_limp;
    logic                      rate_locked;
    logic [1:0]                rate_code;
    logic [7:0]                volume;
    logic                      pclk_from_mclk;
    logic [23:0]               wire_acc    = 24'h000000;
    logic [23:0]               wire_left   = 24'h000000;
    logic                      lr_prev     = 1'b0;
    int                        bit_pos     = 0;
    int                        first_pos   = 1;
    int                        wl          = 24;
    int                        num_errors  = 0;
    int                        total_checks = 0;
    int                        cycle_count = 0;

    asicm_link_if asicm_link_if_i ();
    asicm_source asicm_source_i (.clk_sys(clk_sys), .sys_rst(src_rst), .link(asicm_link_if_i),
        .fmt(fmt), .wlen(wlen), .ratio(ratio), .left_in(left_in), .right_in(right_in),
        .sample_take());
    asicm_receiver asicm_receiver_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(asicm_link_if_i),
        .fmt(fmt), .wlen(wlen), .soft_unmute(soft_unmute), .left_sample(left_sample),
        .left_valid(left_valid), .right_sample(right_sample), .right_valid(right_valid),
        .muted(muted), .pll_limp(pll_limp), .rate_locked(rate_locked), .rate_code(rate_code),
        .volume(volume), .pclk_from_mclk(pclk_from_mclk));
    asicm_checker asicm_checker_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .mclk(asicm_link_if_i.mclk), .bclk(asicm_link_if_i.bclk), .lrclk(asicm_link_if_i.lrclk),
        .soft_unmute(soft_unmute), .left_valid(left_valid), .right_valid(right_valid),
        .muted(muted), .pll_limp(pll_limp), .rate_locked(rate_locked), .volume(volume),
        .pclk_from_mclk(pclk_from_mclk));

    always #2 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    // wire monitor: collects the left word off the line on rising bit clock
    always @(posedge asicm_link_if_i.bclk)
    begin
        if (asicm_link_if_i.lrclk !== lr_prev)
        begin
            if (lr_prev === (fmt != asicm_pkg::ASICM_FMT_I2S))
                wire_left = wire_acc;
            wire_acc = 24'h000000;
            bit_pos = 0;
            lr_prev = asicm_link_if_i.lrclk;
        end
        if (bit_pos >= first_pos && bit_pos < first_pos + wl)
            wire_acc = {wire_acc[22:0], asicm_link_if_i.serial_audio_in};
        bit_pos = bit_pos + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic cond(input int k);
        case (k)
            0: return muted === 1'b0;
            1: return muted === 1'b1;
            2: return left_valid === 1'b1;
            default: return right_valid === 1'b1;
        endcase
    endfunction

    task automatic wait_for(input int k, input int limit);
        int n;
        n = 0;
        while (!cond(k) && n < limit)
        begin
            tick();
            n++;
        end
        if (n >= limit)
        begin
            num_errors++;
            $display("MISMATCH t=%0t wait=%h limit=%h", $time, k, limit);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock loss: source held in reset stops every link clock
    task automatic stop_source();
        src_rst = 1'b1;
        wait_for(1, 400);
        check_word({23'h0, muted}, 24'h1);
        check_word({23'h0, pll_limp}, 24'h1);
        check_word({16'h0, volume}, 24'h0);
        repeat (200) tick();
        check_word({23'h0, pclk_from_mclk}, 24'h0);
        $display("test done: clock loss");
    endtask

    task automatic run_cfg(input asicm_pkg::asicm_fmt_type f, input asicm_pkg::asicm_wlen_type w,
        input logic [6:0] r);
        logic [23:0] mask;
        stop_source();
        fmt = f;
        wlen = w;
        ratio = r;
        wl = 16 + 4 * int'(w);
        mask = ~(24'hFFFFFF >> wl);
        first_pos = (f == asicm_pkg::ASICM_FMT_I2S) ? 1 : (f == asicm_pkg::ASICM_FMT_LJ) ? 0 :
            int'(r) / 2 - wl;
        src_rst = 1'b0;
        wait_for(0, 9000);
        check_word({23'h0, muted}, 24'h0);
        check_word({16'h0, volume}, 24'h0000FF);
        check_word({22'h0, rate_code}, (r == asicm_pkg::RATIO_64) ? 24'h2 :
            (r == asicm_pkg::RATIO_48) ? 24'h1 : 24'h0);
        wait_for(2, 2000);
        check_word(left_sample, left_in & mask);
        wait_for(3, 2000);
        check_word(right_sample, right_in & mask);
        check_word(wire_left, left_in >> (24 - wl));
        check_word({23'h0, pclk_from_mclk}, 24'h1);
        $display("test done: fmt=%0d bits=%0d ratio=%0d", f, wl, r);
    endtask

    task automatic soft_case();
        stop_source();
        soft_unmute = 1'b1;
        src_rst = 1'b0;
        wait_for(0, 9000);
        repeat (40) tick();
        check_word({23'h0, volume != 8'h00 && volume != 8'hFF}, 24'h1);
        repeat (4200) tick();
        check_word({16'h0, volume}, 24'h0000FF);
        $display("test done: soft unmute");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        cycle_count++;
        if (cycle_count == 90000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check_word({20'h0, muted, pll_limp, rate_locked, left_valid}, 24'hC);
        check_word({16'h0, volume}, 24'h0);
        $display("test done: reset");
        run_cfg(asicm_pkg::ASICM_FMT_I2S, asicm_pkg::ASICM_WL_24, asicm_pkg::RATIO_64);
        run_cfg(asicm_pkg::ASICM_FMT_LJ, asicm_pkg::ASICM_WL_24, asicm_pkg::RATIO_48);
        run_cfg(asicm_pkg::ASICM_FMT_RJ, asicm_pkg::ASICM_WL_24, asicm_pkg::RATIO_64);
        run_cfg(asicm_pkg::ASICM_FMT_RJ, asicm_pkg::ASICM_WL_16, asicm_pkg::RATIO_32);
        run_cfg(asicm_pkg::ASICM_FMT_I2S, asicm_pkg::ASICM_WL_20, asicm_pkg::RATIO_48);
        run_cfg(asicm_pkg::ASICM_FMT_LJ, asicm_pkg::ASICM_WL_16, asicm_pkg::RATIO_32);
        run_cfg(asicm_pkg::ASICM_FMT_RJ, asicm_pkg::ASICM_WL_20, asicm_pkg::RATIO_48);
        soft_case();
        complete_run();
    end
endmodule
`default_nettype wire
